// *** design/mtcpc_pkg.sv ***
// Shared constants and types for the minute time code pulse codec
package mtcpc_pkg;

  // Clock rate and the millisecond time base
  localparam int unsigned CLK_HZ          = 200_000_000;
  localparam int unsigned TICK_PERIOD_US  = 1000;
  localparam int unsigned TICK_CYCLES     = (CLK_HZ / 1_000_000) * TICK_PERIOD_US;

  // Millisecond figures within one second, plus the minute gap
  localparam int          MS_W            = 11;
  localparam logic [10:0] SEC_LAST_MS     = 11'h3e7;  // 999 ms
  localparam logic [10:0] ZERO_WIDTH_MS   = 11'h064;  // 100 ms
  localparam logic [10:0] ONE_WIDTH_MS    = 11'h0c8;  // 200 ms
  localparam logic [10:0] SPLIT_WIDTH_MS  = 11'h096;  // 150 ms
  localparam logic [10:0] MINUTE_GAP_MS   = 11'h5dc;  // 1500 ms
  localparam logic [10:0] MS_SAT          = 11'h7ff;

  // Seconds and frame
  localparam int          FRAME_BITS      = 59;
  localparam logic [5:0]  SEC_GAP         = 6'h3b;    // 59
  localparam logic [5:0]  IDX_SAT         = 6'h3f;

  // Bit positions in the minute frame
  localparam int POS_MARK      = 0;
  localparam int POS_STANDBY   = 15;
  localparam int POS_CHANGE    = 16;
  localparam int POS_ZONE1     = 17;
  localparam int POS_ZONE2     = 18;
  localparam int POS_LEAP      = 19;
  localparam int POS_START     = 20;
  localparam int POS_MIN       = 21;
  localparam int POS_MIN_CHK   = 28;
  localparam int POS_HOUR      = 29;
  localparam int POS_HOUR_CHK  = 35;
  localparam int POS_DATE      = 36;
  localparam int POS_DATE_CHK  = 58;
  localparam int DATE_BITS     = 22;

  // Hour arithmetic
  localparam logic [4:0]  STD_OFFSET_H    = 5'h01;
  localparam logic [4:0]  HOURS_PER_DAY   = 5'h18;
  localparam logic [5:0]  HOURS_PER_DAY6  = 6'h18;

  // BCD time and date of one minute; date fields sit low to high as day..year
  typedef struct packed {
    logic [7:0] year;
    logic [4:0] month;
    logic [2:0] wday;
    logic [5:0] day;
    logic [5:0] hour;
    logic [6:0] minute;
  } mtcpc_time_type;

  typedef struct packed {
    logic standby;
    logic change;
    logic summer;
    logic leap;
  } mtcpc_flags_type;

  typedef enum logic [0:0] {
    MTCPC_IDLE = 1'b0,
    MTCPC_RUN  = 1'b1
  } mtcpc_enc_state_type;

endpackage

// *** design/mtcpc_tick.sv ***
// Millisecond enable divider
`timescale 1ns/1ps
`default_nettype none
module mtcpc_tick #(
  parameter int unsigned DIV = mtcpc_pkg::TICK_CYCLES
) (
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  input  wire logic i_run,
  output logic      o_tick
);
  // A divide of one still needs a one-bit counter
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } mtcpc_tick_state_type;

  mtcpc_tick_state_type s;
  mtcpc_tick_state_type next_s;

  always_comb begin
    next_s      = s;
    next_s.tick = 1'b0;
    if (!i_run) begin
      next_s.cnt = '0;
    end else if (s.cnt == CW'(DIV - 1)) begin
      next_s.cnt  = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = CW'(s.cnt + 1'b1);
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_tick = s.tick;
endmodule
`default_nettype wire

// *** design/mtcpc_even_parity.sv ***
// Even parity over a group of bits
`timescale 1ns/1ps
`default_nettype none
module mtcpc_even_parity #(
  parameter int W = 7
) (
  input  wire logic [W-1:0] i_bits,
  output logic              o_parity
);
  // Parity bit that makes the group plus itself hold an even count of ones
  assign o_parity = ^i_bits;
endmodule
`default_nettype wire

// *** design/mtcpc_codec.sv ***
// Minute time code pulse encoder and decoder
`timescale 1ns/1ps
`default_nettype none
module mtcpc_codec #(
  parameter int unsigned TICK_CYCLES = mtcpc_pkg::TICK_CYCLES
) (
  input  wire logic                       i_mclk,
  input  wire logic                       i_rst_n,
  input  wire logic                       i_pulse_active_high,
  input  wire logic                       i_enc_enable,
  input  wire mtcpc_pkg::mtcpc_time_type  i_enc_time,
  input  wire mtcpc_pkg::mtcpc_flags_type i_enc_flags,
  output logic                            o_enc_line,
  output logic [5:0]                      o_enc_second,
  output logic                            o_enc_minute_load,
  input  wire logic                       i_dec_enable,
  input  wire logic                       i_dec_line,
  input  wire logic [4:0]                 i_utc_offset,
  output mtcpc_pkg::mtcpc_time_type       o_dec_time,
  output mtcpc_pkg::mtcpc_flags_type      o_dec_flags,
  output logic [4:0]                      o_dec_utc_hour,
  output logic                            o_dec_utc_day_back,
  output logic                            o_dec_valid,
  output logic                            o_dec_error,
  output logic [2:0]                      o_dec_check_fail,
  output logic                            o_dec_bit_strobe,
  output logic                            o_dec_bit
);

  typedef struct packed {
    mtcpc_pkg::mtcpc_enc_state_type enc_state;
    logic [5:0]                     enc_sec;
    logic [10:0]                    enc_ms;
    logic [58:0]                    enc_frame;
    logic                           enc_line;
    logic                           enc_load;
    logic [1:0]                     dec_sync;
    logic [2:0]                     dec_armed;
    logic                           dec_prev;
    logic [10:0]                    dec_width;
    logic [10:0]                    dec_gap;
    logic [5:0]                     dec_idx;
    logic [58:0]                    dec_bits;
    mtcpc_pkg::mtcpc_time_type      dec_time;
    mtcpc_pkg::mtcpc_flags_type     dec_flags;
    logic [4:0]                     dec_utc_hour;
    logic                           dec_day_back;
    logic                           dec_valid;
    logic                           dec_error;
    logic [2:0]                     dec_fail;
    logic                           dec_bit_strobe;
    logic                           dec_bit;
  } mtcpc_codec_state_type;

  mtcpc_codec_state_type s;
  mtcpc_codec_state_type next_s;

  logic        tick;
  logic [4:0]  enc_utc_bin;
  logic [5:0]  enc_local_hour;
  logic [21:0] enc_date;
  logic [2:0]  enc_chk;
  logic [58:0] enc_new_frame;
  logic [2:0]  dec_chk;

  // Hour fields only: the tens digit never passes 2
  function automatic logic [4:0] bcd_to_bin(input logic [5:0] b);
    return ({3'h0, b[5:4]} * 5'h0a) + {1'b0, b[3:0]};
  endfunction

  function automatic logic [5:0] bin_to_bcd(input logic [4:0] v);
    logic [4:0] r;
    r = 5'h00;
    if (v >= 5'h14) begin
      r = v - 5'h14;
      return {2'h2, r[3:0]};
    end else if (v >= 5'h0a) begin
      r = v - 5'h0a;
      return {2'h1, r[3:0]};
    end
    return {2'h0, v[3:0]};
  endfunction

  // One shared millisecond base; both halves count whole milliseconds
  mtcpc_tick #(
    .DIV (TICK_CYCLES)
  ) u_tick (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_run   (i_enc_enable | i_dec_enable),
    .o_tick  (tick)
  );

  // Local hour from UTC: standard offset, one more hour in summer
  always_comb begin
    logic [4:0] sum;
    sum         = 5'h00;
    enc_utc_bin = bcd_to_bin(i_enc_time.hour);
    sum         = enc_utc_bin + mtcpc_pkg::STD_OFFSET_H + {4'h0, i_enc_flags.summer};
    if (sum >= mtcpc_pkg::HOURS_PER_DAY) begin
      sum = sum - mtcpc_pkg::HOURS_PER_DAY;
    end
    enc_local_hour = bin_to_bcd(sum);
  end

  // Date group in frame order: day, weekday, month, year
  assign enc_date = {i_enc_time.year, i_enc_time.month, i_enc_time.wday, i_enc_time.day};

  mtcpc_even_parity #(.W(7)) u_enc_min_chk (
    .i_bits   (i_enc_time.minute),
    .o_parity (enc_chk[0])
  );
  mtcpc_even_parity #(.W(6)) u_enc_hour_chk (
    .i_bits   (enc_local_hour),
    .o_parity (enc_chk[1])
  );
  mtcpc_even_parity #(.W(mtcpc_pkg::DATE_BITS)) u_enc_date_chk (
    .i_bits   (enc_date),
    .o_parity (enc_chk[2])
  );

  // Frame for the coming minute
  always_comb begin
    enc_new_frame                              = '0;
    enc_new_frame[mtcpc_pkg::POS_MARK]         = 1'b0;
    enc_new_frame[mtcpc_pkg::POS_STANDBY]      = i_enc_flags.standby;
    enc_new_frame[mtcpc_pkg::POS_CHANGE]       = i_enc_flags.change;
    enc_new_frame[mtcpc_pkg::POS_ZONE1]        = i_enc_flags.summer;
    enc_new_frame[mtcpc_pkg::POS_ZONE2]        = ~i_enc_flags.summer;
    enc_new_frame[mtcpc_pkg::POS_LEAP]         = i_enc_flags.leap;
    enc_new_frame[mtcpc_pkg::POS_START]        = 1'b1;
    enc_new_frame[mtcpc_pkg::POS_MIN +: 7]     = i_enc_time.minute;
    enc_new_frame[mtcpc_pkg::POS_MIN_CHK]      = enc_chk[0];
    enc_new_frame[mtcpc_pkg::POS_HOUR +: 6]    = enc_local_hour;
    enc_new_frame[mtcpc_pkg::POS_HOUR_CHK]     = enc_chk[1];
    enc_new_frame[mtcpc_pkg::POS_DATE +: 22]   = enc_date;
    enc_new_frame[mtcpc_pkg::POS_DATE_CHK]     = enc_chk[2];
  end

  // Parity of the collected bits; only read at the minute mark
  mtcpc_even_parity #(.W(7)) u_dec_min_chk (
    .i_bits   (s.dec_bits[mtcpc_pkg::POS_MIN +: 7]),
    .o_parity (dec_chk[0])
  );
  mtcpc_even_parity #(.W(6)) u_dec_hour_chk (
    .i_bits   (s.dec_bits[mtcpc_pkg::POS_HOUR +: 6]),
    .o_parity (dec_chk[1])
  );
  mtcpc_even_parity #(.W(mtcpc_pkg::DATE_BITS)) u_dec_date_chk (
    .i_bits   (s.dec_bits[mtcpc_pkg::POS_DATE +: 22]),
    .o_parity (dec_chk[2])
  );

  always_comb begin
    logic        active_out;
    logic        active_in;
    logic [10:0] width;
    logic [2:0]  fail;
    logic [4:0]  loc;
    logic [5:0]  utc6;
    active_out = 1'b0;
    active_in  = 1'b0;
    width      = mtcpc_pkg::ZERO_WIDTH_MS;
    fail       = 3'h0;
    loc        = 5'h00;
    utc6       = 6'h00;
    next_s     = s;
    next_s.enc_load       = 1'b0;
    next_s.dec_valid      = 1'b0;
    next_s.dec_error      = 1'b0;
    next_s.dec_bit_strobe = 1'b0;

    // Encoder
    unique case (s.enc_state)
      mtcpc_pkg::MTCPC_IDLE: begin
        next_s.enc_sec   = 6'h00;
        next_s.enc_ms    = 11'h000;
        next_s.enc_frame = enc_new_frame;
        if (i_enc_enable) begin
          // Starting at second 0 keeps the first frame whole
          next_s.enc_state = mtcpc_pkg::MTCPC_RUN;
          next_s.enc_load  = 1'b1;
        end
      end
      mtcpc_pkg::MTCPC_RUN: begin
        if (!i_enc_enable) begin
          next_s.enc_state = mtcpc_pkg::MTCPC_IDLE;
        end else if (tick) begin
          if (s.enc_ms == mtcpc_pkg::SEC_LAST_MS) begin
            next_s.enc_ms = 11'h000;
            if (s.enc_sec == mtcpc_pkg::SEC_GAP) begin
              // While running, new time is taken only at the minute wrap
              next_s.enc_sec   = 6'h00;
              next_s.enc_frame = enc_new_frame;
              next_s.enc_load  = 1'b1;
            end else begin
              next_s.enc_sec = s.enc_sec + 6'h01;
            end
          end else begin
            next_s.enc_ms = s.enc_ms + 11'h001;
          end
        end
      end
    endcase

    // Width judged from the next-state frame and second so the line and the second move together
    if ((next_s.enc_sec != mtcpc_pkg::SEC_GAP)
        && (next_s.enc_sec < 6'(mtcpc_pkg::FRAME_BITS))) begin
      width = next_s.enc_frame[next_s.enc_sec] ? mtcpc_pkg::ONE_WIDTH_MS
                                               : mtcpc_pkg::ZERO_WIDTH_MS;
    end
    active_out = (next_s.enc_state == mtcpc_pkg::MTCPC_RUN)
                 && (next_s.enc_sec != mtcpc_pkg::SEC_GAP)
                 && (next_s.enc_ms < width);
    next_s.enc_line = i_pulse_active_high ? active_out : ~active_out;

    // Decoder: two flip-flops before the line is looked at
    next_s.dec_sync = {s.dec_sync[0], i_dec_line};
    active_in       = i_pulse_active_high ? s.dec_sync[1] : ~s.dec_sync[1];
    next_s.dec_prev = active_in;
    // Sync flops reset low, a pulse under low polarity: no edges until they are filled
    next_s.dec_armed = {s.dec_armed[1:0], 1'b1};

    if (!i_dec_enable) begin
      next_s.dec_idx   = mtcpc_pkg::IDX_SAT;
      next_s.dec_width = 11'h000;
      next_s.dec_gap   = 11'h000;
    end else begin
      if (tick) begin
        if (active_in && (s.dec_width != mtcpc_pkg::MS_SAT)) begin
          next_s.dec_width = s.dec_width + 11'h001;
        end
        if (!active_in && (s.dec_gap != mtcpc_pkg::MS_SAT)) begin
          next_s.dec_gap = s.dec_gap + 11'h001;
        end
      end
      if (active_in && !s.dec_prev && s.dec_armed[2]) begin
        next_s.dec_width = 11'h000;
        next_s.dec_gap   = 11'h000;
        // A missing pulse means this edge opens a new minute
        if (s.dec_gap >= mtcpc_pkg::MINUTE_GAP_MS) begin
          next_s.dec_idx = 6'h00;
          if (s.dec_idx == 6'(mtcpc_pkg::FRAME_BITS)) begin
            fail[0] = dec_chk[0] != s.dec_bits[mtcpc_pkg::POS_MIN_CHK];
            fail[1] = dec_chk[1] != s.dec_bits[mtcpc_pkg::POS_HOUR_CHK];
            fail[2] = dec_chk[2] != s.dec_bits[mtcpc_pkg::POS_DATE_CHK];
            next_s.dec_fail = fail;
            if ((fail == 3'h0) && s.dec_bits[mtcpc_pkg::POS_START]
                && !s.dec_bits[mtcpc_pkg::POS_MARK]) begin
              next_s.dec_valid          = 1'b1;
              next_s.dec_time.minute    = s.dec_bits[mtcpc_pkg::POS_MIN +: 7];
              next_s.dec_time.hour      = s.dec_bits[mtcpc_pkg::POS_HOUR +: 6];
              {next_s.dec_time.year, next_s.dec_time.month,
               next_s.dec_time.wday, next_s.dec_time.day}
                = s.dec_bits[mtcpc_pkg::POS_DATE +: 22];
              next_s.dec_flags.standby  = s.dec_bits[mtcpc_pkg::POS_STANDBY];
              next_s.dec_flags.change   = s.dec_bits[mtcpc_pkg::POS_CHANGE];
              next_s.dec_flags.summer   = s.dec_bits[mtcpc_pkg::POS_ZONE1];
              next_s.dec_flags.leap     = s.dec_bits[mtcpc_pkg::POS_LEAP];
              // UTC: back off the offset, one hour more in summer
              loc  = bcd_to_bin(s.dec_bits[mtcpc_pkg::POS_HOUR +: 6]);
              utc6 = {1'b0, loc} + mtcpc_pkg::HOURS_PER_DAY6 - {1'b0, i_utc_offset}
                     - {5'h00, s.dec_bits[mtcpc_pkg::POS_ZONE1]};
              if (utc6 >= mtcpc_pkg::HOURS_PER_DAY6) begin
                next_s.dec_utc_hour = 5'(utc6 - mtcpc_pkg::HOURS_PER_DAY6);
                next_s.dec_day_back = 1'b0;
              end else begin
                next_s.dec_utc_hour = utc6[4:0];
                next_s.dec_day_back = 1'b1;
              end
            end else begin
              next_s.dec_error = 1'b1;
            end
          end else if (s.dec_idx != mtcpc_pkg::IDX_SAT) begin
            // Wrong bit count: frame dropped; an out-of-step counter only resyncs
            next_s.dec_error = 1'b1;
            next_s.dec_fail  = 3'h0;
          end
        end
      end
      // No glitch filter: a spike on the line reads as a short pulse
      if (!active_in && s.dec_prev && s.dec_armed[2]) begin
        next_s.dec_bit        = s.dec_width >= mtcpc_pkg::SPLIT_WIDTH_MS;
        next_s.dec_bit_strobe = 1'b1;
        if (s.dec_idx < 6'(mtcpc_pkg::FRAME_BITS)) begin
          next_s.dec_bits[s.dec_idx] = s.dec_width >= mtcpc_pkg::SPLIT_WIDTH_MS;
        end
        if (s.dec_idx != mtcpc_pkg::IDX_SAT) begin
          next_s.dec_idx = s.dec_idx + 6'h01;
        end
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      // Bit counter starts out of step, so the first minute only synchronises
      s         <= '0;
      s.dec_idx <= mtcpc_pkg::IDX_SAT;
    end else begin
      s <= next_s;
    end
  end

  // Every output comes straight from the state register
  assign o_enc_line         = s.enc_line;
  assign o_enc_second       = s.enc_sec;
  assign o_enc_minute_load  = s.enc_load;
  assign o_dec_time         = s.dec_time;
  assign o_dec_flags        = s.dec_flags;
  assign o_dec_utc_hour     = s.dec_utc_hour;
  assign o_dec_utc_day_back = s.dec_day_back;
  assign o_dec_valid        = s.dec_valid;
  assign o_dec_error        = s.dec_error;
  assign o_dec_check_fail   = s.dec_fail;
  assign o_dec_bit_strobe   = s.dec_bit_strobe;
  assign o_dec_bit          = s.dec_bit;
endmodule
`default_nettype wire

// *** tb/mtcpc_codec_props.sv ***
// Port-level property checker for the minute time code pulse codec
`timescale 1ns/1ps
`default_nettype none
module mtcpc_codec_props #(
  parameter int unsigned TICK_CYCLES = 1
) (
  input wire logic       i_mclk,
  input wire logic       i_rst_n,
  input wire logic       i_pulse_active_high,
  input wire logic       i_enc_enable,
  input wire logic       o_enc_line,
  input wire logic [5:0] o_enc_second,
  input wire logic       o_enc_minute_load,
  input wire logic       i_dec_line,
  input wire logic       o_dec_valid,
  input wire logic       o_dec_error,
  input wire logic [2:0] o_dec_check_fail
);
  localparam int W0  = 100 * TICK_CYCLES;
  localparam int W1  = 200 * TICK_CYCLES;
  localparam int SEC = 1000 * TICK_CYCLES;
  logic act;
  logic dact;
  logic act_q;
  int   wid;
  int   per;
  assign act  = (o_enc_line == i_pulse_active_high);
  assign dact = (i_dec_line == i_pulse_active_high);
  // Width count clears while disabled, so the idle level seen just after reset is ignored
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      act_q <= 1'b0;
      wid   <= 0;
      per   <= 0;
    end else begin
      act_q <= act;
      wid   <= (act && i_enc_enable) ? wid + 1 : 0;
      per   <= (act && !act_q) ? 1 : per + 1;
    end
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  sequence s_idle2;
    !i_enc_enable ##1 !i_enc_enable;
  endsequence
  sequence s_dec_done;
    o_dec_valid || o_dec_error;
  endsequence
  AST_LOAD: assert property (o_enc_minute_load |-> o_enc_second == 6'h00 && act)
    else $error("minute load without pulse at second zero");
  AST_SILENT: assert property (o_enc_second == 6'h3b |-> !act)
    else $error("pulse seen in the silent second");
  AST_EDGE: assert property ($changed(o_enc_second) && o_enc_second != 6'h00
    && o_enc_second != 6'h3b |-> act)
    else $error("second changed without pulse start");
  AST_STEP: assert property ($changed(o_enc_second) && o_enc_second != 6'h00
    |-> o_enc_second == $past(o_enc_second) + 6'h01)
    else $error("second count skipped");
  AST_WRAP: assert property ($past(o_enc_second) == 6'h3b && o_enc_second == 6'h00
    |-> o_enc_minute_load)
    else $error("no new frame after the silent second");
  AST_WIDTH: assert property (!act && wid != 0 |-> wid == W0 || wid == W1)
    else $error("pulse width neither short nor long");
  AST_PERIOD: assert property (act && !act_q && o_enc_second != 6'h00 |-> per == SEC)
    else $error("pulse start off the second grid");
  AST_IDLE: assert property (s_idle2 |-> !act)
    else $error("line active while encoder disabled");
  AST_DEC_GAP: assert property (s_dec_done |-> dact && !$past(dact, 12))
    else $error("decode result not at a leading edge after a gap");
  AST_DEC_OK: assert property (o_dec_valid |-> !o_dec_error ##1
    o_dec_check_fail == 3'h0 && !o_dec_valid)
    else $error("good frame with parity failure flagged");
endmodule
`default_nettype wire

// *** tb/mtcpc_slave_model.sv ***
// Behavioural slave clock that reads the pulse line
`timescale 1ns/1ps
`default_nettype none
module mtcpc_slave_model #(
  parameter int TICK_CYCLES = 1
) (
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire logic        i_line,
  input  wire logic        i_pol,
  output logic      [58:0] o_bits,
  output logic      [5:0]  o_idx,
  output logic             o_bad
);
  int wid;
  int gap;
  int per;
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wid = 0;
      gap = 2000 * TICK_CYCLES;
      per = 0;
      o_bits = '0;
      o_idx = 6'h00;
      o_bad = 1'b0;
    end else if (i_line == i_pol) begin
      per = per + 1;
      if (wid == 0) begin
        if (gap >= 1500 * TICK_CYCLES) begin
          o_idx = 6'h00;
        end else if (per != 1000 * TICK_CYCLES) begin
          o_bad = 1'b1;
        end
        per = 0;
      end
      wid = wid + 1;
      gap = 0;
    end else begin
      per = per + 1;
      gap = gap + 1;
      if (wid != 0) begin
        if (wid != 100 * TICK_CYCLES && wid != 200 * TICK_CYCLES) begin
          o_bad = 1'b1;
        end
        // Bits past the frame end are dropped, as a real slave would
        if (o_idx < 6'h3b) begin
          o_bits[o_idx] = (wid >= 150 * TICK_CYCLES);
          o_idx = o_idx + 6'h01;
        end
      end
      wid = 0;
    end
  end
endmodule
`default_nettype wire

// *** tb/tb_minute_time_code_pulse_codec.sv ***
// Self-checking bench for the minute time code pulse codec
`timescale 1ns/1ps
`default_nettype none
module tb_minute_time_code_pulse_codec;
  // One clock per millisecond keeps a full minute near 60000 cycles
  localparam int unsigned TC = 1;
  logic                       mclk = 1'b0;
  logic                       rst_n = 1'b0;
  logic                       prst_n = 1'b0;
  logic                       pol = 1'b0;
  logic                       enc_en = 1'b0;
  logic                       dec_en = 1'b1;
  logic [4:0]                 offset = 5'h01;
  logic                       dec_line = 1'b0;
  mtcpc_pkg::mtcpc_time_type  enc_time = '0;
  mtcpc_pkg::mtcpc_flags_type enc_flags = '0;
  mtcpc_pkg::mtcpc_time_type  exp_t;
  mtcpc_pkg::mtcpc_time_type  dec_time;
  mtcpc_pkg::mtcpc_flags_type dec_flags;
  logic                       enc_line;
  logic [5:0]                 sec;
  logic                       load;
  logic [4:0]                 utc_hour;
  logic                       day_back;
  logic                       dec_valid;
  logic                       dec_err;
  logic [2:0]                 check_fail;
  logic [58:0]                s_bits;
  logic [5:0]                 s_idx;
  logic                       s_bad;
  logic                       dec_stb;
  logic                       dec_bit;
  int                         n_stb = 0;
  int                         err_total = 0;
  int                         n_compared = 0;
  int                         cycles = 0;

  mtcpc_codec #(.TICK_CYCLES(TC)) dut (
    .i_mclk              (mclk),
    .i_rst_n             (rst_n),
    .i_pulse_active_high (pol),
    .i_enc_enable        (enc_en),
    .i_enc_time          (enc_time),
    .i_enc_flags         (enc_flags),
    .o_enc_line          (enc_line),
    .o_enc_second        (sec),
    .o_enc_minute_load   (load),
    .i_dec_enable        (dec_en),
    .i_dec_line          (dec_line),
    .i_utc_offset        (offset),
    .o_dec_time          (dec_time),
    .o_dec_flags         (dec_flags),
    .o_dec_utc_hour      (utc_hour),
    .o_dec_utc_day_back  (day_back),
    .o_dec_valid         (dec_valid),
    .o_dec_error         (dec_err),
    .o_dec_check_fail    (check_fail),
    .o_dec_bit_strobe    (dec_stb),
    .o_dec_bit           (dec_bit)
  );

  mtcpc_slave_model #(.TICK_CYCLES(TC)) u_slave (
    .i_mclk  (mclk),
    .i_rst_n (prst_n),
    .i_line  (enc_line),
    .i_pol   (pol),
    .o_bits  (s_bits),
    .o_idx   (s_idx),
    .o_bad   (s_bad)
  );

  always #2.5 mclk = ~mclk;
  // Loop the encoder back into the decoder, changed off the sampling edge
  always @(negedge mclk) dec_line <= enc_line;
  always @(posedge mclk) begin
    if (dec_stb === 1'b1) begin
      n_stb++;
    end
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 100000) begin
      err_total++;
      close_out();
    end
  end

  task automatic close_out();
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [58:0] frame(input mtcpc_pkg::mtcpc_time_type t,
                                        input mtcpc_pkg::mtcpc_flags_type f);
    logic [58:0] b;
    b = '0;
    b[15] = f.standby;
    b[16] = f.change;
    b[17] = f.summer;
    b[18] = !f.summer;
    b[19] = f.leap;
    b[20] = 1'b1;
    b[27:21] = t.minute;
    b[28] = ^t.minute;
    b[34:29] = t.hour;
    b[35] = ^t.hour;
    b[57:36] = {t.year, t.month, t.wday, t.day};
    b[58] = ^b[57:36];
    return b;
  endfunction

  // Slave reset trails the design so the reset-time line level is not read as a pulse
  task automatic do_reset(input logic p, input int n);
    rst_n = 1'b0;
    prst_n = 1'b0;
    pol = p;
    repeat (n) @(negedge mclk);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    prst_n = 1'b1;
  endtask

  task automatic t_polarity();
    do_reset(1'b0, 20);
    chk(enc_line, 64'h1);
    do_reset(1'b1, 3);
    chk(enc_line, 64'h0);
    $display("Test polarity done");
  endtask

  task automatic t_frame_a();
    logic [58:0] exp;
    int          base;
    enc_time = '{year: 8'h99, month: 5'h12, wday: 3'h7, day: 6'h31, hour: 6'h22, minute: 7'h59};
    enc_flags = 4'ha;
    exp_t = enc_time;
    exp_t.hour = 6'h00;
    exp = frame(exp_t, enc_flags);
    repeat (1600 * TC) @(negedge mclk);
    enc_en = 1'b1;
    while (load !== 1'b1) @(negedge mclk);
    chk(sec, 64'h0);
    base = n_stb;
    while (sec !== 6'h3b) @(negedge mclk);
    chk(s_bits, exp);
    chk(s_idx, 64'h3b);
    enc_flags = 4'h5;
    while (dec_valid !== 1'b1 && dec_err !== 1'b1) @(negedge mclk);
    chk(dec_valid, 64'h1);
    chk(dec_time, exp_t);
    chk(dec_flags, 64'ha);
    chk(utc_hour, 64'h16);
    chk(day_back, 64'h1);
    chk(n_stb - base, 64'h3b);
    chk(dec_bit, exp[58]);
    @(negedge mclk);
    chk(check_fail, 64'h0);
    $display("Test full frame done");
  endtask

  task automatic t_abort();
    logic [58:0] exp;
    exp = frame(exp_t, 4'h5);
    while (sec !== 6'h15) @(negedge mclk);
    repeat (400 * TC) @(negedge mclk);
    chk(s_bits[20:0], exp[20:0]);
    enc_en = 1'b0;
    repeat (2) @(negedge mclk);
    chk(enc_line, !pol);
    repeat (1600 * TC) @(negedge mclk);
    enc_en = 1'b1;
    while (dec_err !== 1'b1 && dec_valid !== 1'b1) @(negedge mclk);
    chk(dec_err, 64'h1);
    @(negedge mclk);
    chk(check_fail, 64'h0);
    chk(dec_time, exp_t);
    chk(s_bad, 64'h0);
    $display("Test short frame done");
  endtask

  initial begin
    t_polarity();
    t_frame_a();
    t_abort();
    close_out();
  end
endmodule

bind mtcpc_codec mtcpc_codec_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (
  .i_mclk, .i_rst_n, .i_pulse_active_high, .i_enc_enable, .o_enc_line, .o_enc_second,
  .o_enc_minute_load, .i_dec_line, .o_dec_valid, .o_dec_error, .o_dec_check_fail
);
`default_nettype wire
